/* pkg/dbr_pkg.sv */
package dbr_pkg;
   // Bank geometry
   localparam int NUM_BANKS  = 32;
   localparam int BANK_W     = 5;
   localparam int HALF_W     = 4;
   localparam int ROW_W      = 9;
   localparam int COL_W      = 7;
   localparam int SA_SEL_BIT = 6;
   localparam logic [HALF_W-1:0] HALF_FIRST = 4'h0;
   localparam logic [HALF_W-1:0] HALF_LAST  = 4'hf;

   // Clock and interval minimums
   localparam int CLK_MHZ    = 25;
   localparam int T_RCD_NS   = 80;
   localparam int T_RAS_NS   = 200;
   localparam int T_RP_NS    = 80;
   localparam int T_OFFP_NS  = 120;
   localparam int T_RTR_NS   = 80;
   localparam int CNT_W      = 4;

   function automatic int ns_to_cyc_up(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc_up

   localparam logic [CNT_W-1:0] RCD_CYC  = CNT_W'(ns_to_cyc_up(T_RCD_NS));
   localparam logic [CNT_W-1:0] RAS_CYC  = CNT_W'(ns_to_cyc_up(T_RAS_NS));
   localparam logic [CNT_W-1:0] RP_CYC   = CNT_W'(ns_to_cyc_up(T_RP_NS));
   localparam logic [CNT_W-1:0] OFFP_CYC = CNT_W'(ns_to_cyc_up(T_OFFP_NS));
   localparam logic [CNT_W-1:0] RTR_CYC  = CNT_W'(ns_to_cyc_up(T_RTR_NS));
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

   // Row packet commands
   typedef enum logic [1:0] {
      ROW_ACT, ROW_PRE, ROW_REF_ACT, ROW_REF_PRE
   } dbr_row_op_e;

   // Column packet commands
   typedef enum logic [2:0] {
      COL_NOP, COL_RD, COL_WR, COL_RD_AP, COL_WR_AP
   } dbr_col_op_e;
endpackage : dbr_pkg

/* rtl/dbr_bank_ctrl.sv */
// Behaviour
// RL1: Controller spaces same-bank activates by row cycle
// RL2: Controller keeps neighbours of active bank precharged
// RL3: Row commands one packet apart, except conflicts
// RL4: Activate starts automatic internal restore
// RL5: Written data propagates into active row
// RL6: Precharge only after restore and column work
// RL7: Activate, restore, precharge intervals; columns during restore
// RL8: Edge sense amps 0,15,16,31 not shared
// RL9: Activate claims both flanking sense amps
// RL10: 512 rows, 1kbyte per sense amp
// RL11: Row precharge respects active and precharge minimums
// RL12: Read auto-precharge fires offset after column packet
// RL13: Controller treats read auto-precharge as two commands
// RL14: Write auto-precharge fires after buffer retires
// RL15: Controller treats write auto-precharge as two commands
// RL16: Retire one interval later, postponed by read
// RL17: Extended-column precharge fires offset after packet
// RL18: Refresh commands count as activate and precharge
// RL19: Flag activate to active or neighbour-busy bank
module dbr_bank_ctrl #(
   parameter int NB = dbr_pkg::NUM_BANKS
) (
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rst_b,
   // Row packet
   input  wire logic                         row_valid,
   input  wire dbr_pkg::dbr_row_op_e         row_op,
   input  wire logic [dbr_pkg::BANK_W-1:0]   row_bank,
   input  wire logic [dbr_pkg::ROW_W-1:0]    row_addr,
   // Column packet
   input  wire logic                         col_valid,
   input  wire logic                         col_dev_match,
   input  wire dbr_pkg::dbr_col_op_e         col_op,
   input  wire logic [dbr_pkg::BANK_W-1:0]   col_bank,
   input  wire logic [dbr_pkg::COL_W-1:0]    col_addr,
   // Extended column packet
   input  wire logic                         ext_valid,
   input  wire logic                         ext_col_precharge_cmd,
   input  wire logic [dbr_pkg::BANK_W-1:0]   ext_bank,
   // Bank state
   output logic [NB-1:0]                     bank_active,
   output logic [NB-1:0]                     bank_restoring,
   output logic [NB-1:0]                     bank_col_ready,
   output logic [NB-1:0]                     bank_blocked,
   output logic [dbr_pkg::ROW_W-1:0]         open_row,
   // Internal operations
   output logic                              pre_pulse,
   output logic [dbr_pkg::BANK_W-1:0]        pre_bank,
   output logic                              retire_pulse,
   output logic [dbr_pkg::BANK_W-1:0]        retire_bank,
   output logic                              col_sa_upper,
   output logic                              act_violation
);
   localparam int BW = dbr_pkg::BANK_W;
   localparam int CW = dbr_pkg::CNT_W;
   // Offset and retire counters act one cycle after reaching zero, so they load one short
   localparam logic [CW-1:0] OFFP_LOAD = dbr_pkg::OFFP_CYC - 1'b1;
   localparam logic [CW-1:0] RTR_LOAD  = dbr_pkg::RTR_CYC - 1'b1;

   typedef struct packed {
      logic [NB-1:0]          active;
      logic [NB-1:0]          restoring;
      logic [NB-1:0]          col_ready;
      logic [NB-1:0]          blocked;
      logic [NB-1:0][CW-1:0]  rcnt;
      logic [dbr_pkg::ROW_W-1:0] row;
      logic                   ap_pend;
      logic [BW-1:0]          ap_bank;
      logic [CW-1:0]          ap_cnt;
      logic                   wb_pend;
      logic                   wb_auto;
      logic [BW-1:0]          wb_bank;
      logic [CW-1:0]          wb_cnt;
      logic                   pre;
      logic [BW-1:0]          pre_bank;
      logic                   retire;
      logic [BW-1:0]          retire_bank;
      logic                   sa_upper;
      logic                   viol;
   } dbr_state_s;

   dbr_state_s s;
   dbr_state_s next_s;

   // Neighbours only within a half; edge banks have one sense amp of their own
   function automatic logic nbr_busy(input logic [NB-1:0] act, input logic [BW-1:0] b);
      logic lo;
      logic hi;
      lo = (b[dbr_pkg::HALF_W-1:0] != dbr_pkg::HALF_FIRST) && act[b - 1'b1];
      hi = (b[dbr_pkg::HALF_W-1:0] != dbr_pkg::HALF_LAST) && act[b + 1'b1];
      return lo | hi;
   endfunction : nbr_busy

   logic act_req;
   logic act_bad;
   logic row_pre_req;
   logic col_here;
   logic col_rd_here;
   logic col_wr_here;
   logic wb_due;
   logic retire_now;

   assign act_req     = row_valid && (row_op == dbr_pkg::ROW_ACT || row_op == dbr_pkg::ROW_REF_ACT);
   assign row_pre_req = row_valid && (row_op == dbr_pkg::ROW_PRE || row_op == dbr_pkg::ROW_REF_PRE);
   assign act_bad     = s.active[row_bank] || nbr_busy(s.active, row_bank);
   assign col_here    = col_valid && col_dev_match;
   assign col_rd_here = col_here && (col_op == dbr_pkg::COL_RD || col_op == dbr_pkg::COL_RD_AP);
   assign col_wr_here = col_here && (col_op == dbr_pkg::COL_WR || col_op == dbr_pkg::COL_WR_AP);
   assign wb_due      = s.wb_pend && (s.wb_cnt == dbr_pkg::CNT_ZERO);
   assign retire_now  = wb_due && col_valid && !col_rd_here;

   always_comb begin
      next_s        = s;
      next_s.pre    = 1'b0;
      next_s.retire = 1'b0;
      next_s.viol   = 1'b0;
      for (int b = 0; b < NB; b++) begin
         if (s.rcnt[b] != dbr_pkg::CNT_ZERO) begin
            next_s.rcnt[b] = s.rcnt[b] - 1'b1;
         end
      end
      // Write buffer retire on the column packet one interval after the write
      if (s.wb_pend && !wb_due) begin
         next_s.wb_cnt = s.wb_cnt - 1'b1;
      end
      if (retire_now) begin // [RL16]
         next_s.retire      = 1'b1; // [RL5]
         next_s.retire_bank = s.wb_bank;
         next_s.wb_pend     = 1'b0;
         if (s.wb_auto) begin // [RL14]
            next_s.ap_pend = 1'b1;
            next_s.ap_bank = s.wb_bank;
            next_s.ap_cnt  = OFFP_LOAD;
         end
      end
      if (col_wr_here) begin
         next_s.wb_pend = 1'b1;
         next_s.wb_auto = (col_op == dbr_pkg::COL_WR_AP);
         next_s.wb_bank = col_bank;
         next_s.wb_cnt  = RTR_LOAD; // [RL16]
      end
      if (col_here && col_op != dbr_pkg::COL_NOP) begin
         next_s.sa_upper = col_addr[dbr_pkg::SA_SEL_BIT]; // [RL10]
      end
      // Offset precharge; a row precharge in the same cycle defers it
      if (s.ap_pend && s.ap_cnt != dbr_pkg::CNT_ZERO) begin
         next_s.ap_cnt = s.ap_cnt - 1'b1;
      end
      if (row_pre_req) begin // [RL18]
         next_s.pre      = 1'b1;
         next_s.pre_bank = row_bank;
      end else if (s.ap_pend && s.ap_cnt == dbr_pkg::CNT_ZERO) begin
         next_s.pre      = 1'b1; // [RL12] [RL17]
         next_s.pre_bank = s.ap_bank;
         next_s.ap_pend  = 1'b0;
      end
      if (col_here && col_op == dbr_pkg::COL_RD_AP) begin // [RL12]
         next_s.ap_pend = 1'b1;
         next_s.ap_bank = col_bank;
         next_s.ap_cnt  = OFFP_LOAD;
      end
      if (ext_valid && ext_col_precharge_cmd) begin // [RL17]
         next_s.ap_pend = 1'b1;
         next_s.ap_bank = ext_bank;
         next_s.ap_cnt  = OFFP_LOAD;
      end
      if (next_s.pre) begin
         next_s.active[next_s.pre_bank] = 1'b0;
         next_s.rcnt[next_s.pre_bank]   = dbr_pkg::RP_CYC; // [RL7]
      end
      if (act_req) begin
         if (act_bad) begin
            next_s.viol = 1'b1; // [RL19]
         end else begin
            next_s.active[row_bank] = 1'b1; // [RL9]
            next_s.rcnt[row_bank]   = dbr_pkg::RAS_CYC; // [RL4]
            next_s.row              = row_addr;
         end
      end
      for (int b = 0; b < NB; b++) begin
         next_s.restoring[b] = next_s.active[b] && (next_s.rcnt[b] != dbr_pkg::CNT_ZERO);
         // Columns open once activation is done, restore may still run
         next_s.col_ready[b] = next_s.active[b] &&
                               (next_s.rcnt[b] <= dbr_pkg::RAS_CYC - dbr_pkg::RCD_CYC); // [RL7]
         next_s.blocked[b]   = nbr_busy(next_s.active, BW'(b)); // [RL8] [RL9]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bank_active    = s.active;
   assign bank_restoring = s.restoring;
   assign bank_col_ready = s.col_ready;
   assign bank_blocked   = s.blocked;
   assign open_row       = s.row;
   assign pre_pulse      = s.pre;
   assign pre_bank       = s.pre_bank;
   assign retire_pulse   = s.retire;
   assign retire_bank    = s.retire_bank;
   assign col_sa_upper   = s.sa_upper;
   assign act_violation  = s.viol;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_act_opens_bank: assert property (act_req && !act_bad && !row_pre_req |=> // [RL4]
      s.active[$past(row_bank)] && s.restoring[$past(row_bank)])
      else $error("activate did not open bank");
   a_act_double: assert property (act_req && s.active[row_bank] |=> s.viol) // [RL19]
      else $error("reactivate not flagged");
   a_act_nbr: assert property (act_req && nbr_busy(s.active, row_bank) |=> // [RL19]
      s.viol && !s.active[$past(row_bank)])
      else $error("neighbour conflict not flagged");
   a_restore_len: assert property (act_req && !act_bad && !row_pre_req |=> // [RL7]
      !s.col_ready[$past(row_bank)])
      else $error("column ready too early");
   a_retire_hold: assert property (wb_due && col_rd_here |=> !s.retire && s.wb_pend) // [RL16]
      else $error("retire not postponed by read");
   a_retire_fire: assert property (retire_now |=> s.retire && // [RL16]
      s.retire_bank == $past(s.wb_bank))
      else $error("retire missed");
   a_rda_offset: assert property (col_here && col_op == dbr_pkg::COL_RD_AP && // [RL12]
      !row_pre_req && !ext_valid |-> ##[1:8] s.pre)
      else $error("read auto-precharge missing");
   a_wra_after: assert property (retire_now && s.wb_auto |-> ##[1:8] s.pre) // [RL14]
      else $error("write auto-precharge missing");
   a_pre_closes: assert property (s.pre |-> !s.active[s.pre_bank]) // [RL7]
      else $error("precharged bank still active");
   a_sa_sel: assert property (col_here && col_op == dbr_pkg::COL_RD |=> // [RL10]
      s.sa_upper == $past(col_addr[dbr_pkg::SA_SEL_BIT]))
      else $error("sense amp select wrong");

   c_act_pre: cover property (act_req ##[1:20] row_pre_req);
   c_retire_delay: cover property (wb_due && col_rd_here ##1 retire_now);
   c_viol: cover property (s.viol);
   c_ext_pre: cover property (ext_valid && ext_col_precharge_cmd ##[1:8] s.pre);
endmodule : dbr_bank_ctrl

/* sim/dbr_ctrl_model.sv */
module dbr_ctrl_model (
   // Clock
   input  wire logic                  clk_sys,
   // Row packet
   output logic                       row_valid,
   output dbr_pkg::dbr_row_op_e       row_op,
   output logic [dbr_pkg::BANK_W-1:0] row_bank,
   output logic [dbr_pkg::ROW_W-1:0]  row_addr,
   // Column packet
   output logic                       col_valid,
   output logic                       col_dev_match,
   output dbr_pkg::dbr_col_op_e       col_op,
   output logic [dbr_pkg::BANK_W-1:0] col_bank,
   output logic [dbr_pkg::COL_W-1:0]  col_addr,
   // Extended column packet
   output logic                       ext_valid,
   output logic                       ext_col_precharge_cmd,
   output logic [dbr_pkg::BANK_W-1:0] ext_bank
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bank, address and match fields flip so a stale value never looks like a packet
   task automatic put(input logic rv, input dbr_pkg::dbr_row_op_e ro, input logic [4:0] rb,
                      input logic [8:0] ra, input logic cv, input logic cm,
                      input dbr_pkg::dbr_col_op_e co, input logic [4:0] cb,
                      input logic [6:0] ca, input logic ev, input logic [4:0] eb);
      row_valid = rv;
      row_op = ro;
      row_bank = rb;
      row_addr = ra;
      col_valid = cv;
      col_dev_match = cm;
      col_op = co;
      col_bank = cb;
      col_addr = ca;
      ext_valid = ev;
      ext_col_precharge_cmd = ev;
      ext_bank = eb;
   endtask : put

   initial put(1'b0, dbr_pkg::ROW_ACT, 5'h00, 9'h000, 1'b0, 1'b0, dbr_pkg::COL_NOP, 5'h00,
               7'h00, 1'b0, 5'h00);

   // Callers space packets by the row, column and offset minimums; only the
   // violation scenario breaks them
   task automatic row(input dbr_pkg::dbr_row_op_e op, input logic [4:0] b, input logic [8:0] a);
      put(1'b1, op, b, a, 1'b0, ~col_dev_match, col_op, ~col_bank, ~col_addr, 1'b0, ~ext_bank);
      @(negedge clk_sys);
   endtask : row

   task automatic col(input dbr_pkg::dbr_col_op_e op, input logic [4:0] b, input logic [6:0] a,
                      input logic mt);
      put(1'b0, row_op, ~row_bank, ~row_addr, 1'b1, mt, op, b, a, 1'b0, ~ext_bank);
      @(negedge clk_sys);
   endtask : col

   task automatic ext(input logic [4:0] b);
      put(1'b0, row_op, ~row_bank, ~row_addr, 1'b0, ~col_dev_match, col_op, ~col_bank,
          ~col_addr, 1'b1, b);
      @(negedge clk_sys);
   endtask : ext

   task automatic idle;
      put(1'b0, row_op, ~row_bank, ~row_addr, 1'b0, ~col_dev_match, col_op, ~col_bank,
          ~col_addr, 1'b0, ~ext_bank);
      @(negedge clk_sys);
   endtask : idle
endmodule : dbr_ctrl_model

/* sim/test_dbr_bank_ctrl.sv */
module test_dbr_bank_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, rst_b, row_valid, col_valid, col_dev_match, ext_valid;
   logic        ext_col_precharge_cmd, pre_pulse, retire_pulse, col_sa_upper, act_violation;
   logic [4:0]  row_bank, col_bank, ext_bank, pre_bank, retire_bank;
   logic [8:0]  row_addr, open_row;
   logic [6:0]  col_addr;
   logic [31:0] bank_active, bank_restoring, bank_col_ready, bank_blocked;
   dbr_pkg::dbr_row_op_e row_op;
   dbr_pkg::dbr_col_op_e col_op;
   int          fails, compares;

   dbr_bank_ctrl dut_u (.clk_sys, .rst_b, .row_valid, .row_op, .row_bank, .row_addr,
      .col_valid, .col_dev_match, .col_op, .col_bank, .col_addr, .ext_valid,
      .ext_col_precharge_cmd, .ext_bank, .bank_active, .bank_restoring, .bank_col_ready,
      .bank_blocked, .open_row, .pre_pulse, .pre_bank, .retire_pulse, .retire_bank,
      .col_sa_upper, .act_violation);
   dbr_ctrl_model m (.clk_sys, .row_valid, .row_op, .row_bank, .row_addr, .col_valid,
      .col_dev_match, .col_op, .col_bank, .col_addr, .ext_valid, .ext_col_precharge_cmd,
      .ext_bank);

   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : chk

   task automatic wait_pre(input logic [4:0] b, input int lo, input int hi);
      int n;
      n = 0;
      while (pre_pulse !== 1'b1 && n < hi) begin
         m.idle();
         n++;
      end
      chk(pre_pulse===1'b1 && pre_bank===b && n >= lo, "offset precharge");
   endtask : wait_pre

   task automatic t_act;
      m.row(dbr_pkg::ROW_ACT, 5'h05, 9'h1a5);
      chk(bank_active[5]===1'b1 && bank_restoring[5]===1'b1 && open_row===9'h1a5, "act");
      chk(bank_blocked[6:4]===3'h5 && bank_col_ready[5]===1'b0, "amps");
      repeat (dbr_pkg::RCD_CYC + 1) m.idle();
      chk(bank_col_ready[5]===1'b1 && bank_restoring[5]===1'b1, "col in restore");
      repeat (dbr_pkg::RAS_CYC) m.idle();
      chk(bank_restoring[5]===1'b0 && bank_active[5]===1'b1, "restore end");
      $display("t_act done");
   endtask : t_act

   task automatic t_viol;
      m.row(dbr_pkg::ROW_ACT, 5'h05, 9'h000);
      chk(act_violation===1'b1 && open_row===9'h1a5, "reopen");
      m.row(dbr_pkg::ROW_ACT, 5'h06, 9'h000);
      chk(act_violation===1'b1 && bank_active[6]===1'b0, "neighbour");
      m.row(dbr_pkg::ROW_ACT, 5'h0f, 9'h00f);
      m.idle();
      m.row(dbr_pkg::ROW_ACT, 5'h10, 9'h010);
      chk(act_violation===1'b0 && bank_active[16:15]===2'h3, "edge act");
      chk(bank_blocked[16:15]===2'h0, "edge amps");
      repeat (dbr_pkg::RAS_CYC) m.idle();
      m.row(dbr_pkg::ROW_PRE, 5'h05, 9'h000);
      chk(pre_pulse===1'b1 && pre_bank===5'h05 && bank_active[5]===1'b0, "pre");
      chk(bank_blocked[6]===1'b0, "amps freed");
      m.idle();
      m.row(dbr_pkg::ROW_REF_PRE, 5'h0f, 9'h000);
      chk(pre_pulse===1'b1 && pre_bank===5'h0f, "ref pre");
      repeat (dbr_pkg::RP_CYC) m.idle();
      m.row(dbr_pkg::ROW_REF_ACT, 5'h0f, 9'h0ff);
      chk(bank_active[15]===1'b1 && open_row===9'h0ff, "ref act");
      $display("t_viol done");
   endtask : t_viol

   task automatic t_wr;
      m.row(dbr_pkg::ROW_ACT, 5'h03, 9'h033);
      repeat (dbr_pkg::RCD_CYC + 1) m.idle();
      m.col(dbr_pkg::COL_WR, 5'h03, 7'h40, 1'b1);
      chk(col_sa_upper===1'b1, "upper amp");
      repeat (dbr_pkg::RTR_CYC) m.idle();
      m.col(dbr_pkg::COL_RD, 5'h03, 7'h01, 1'b1);
      chk(retire_pulse===1'b0, "retire held");
      m.col(dbr_pkg::COL_NOP, 5'h00, 7'h00, 1'b1);
      chk(retire_pulse===1'b1 && retire_bank===5'h03 && col_sa_upper===1'b0, "retire");
      m.col(dbr_pkg::COL_WR_AP, 5'h03, 7'h02, 1'b1);
      repeat (dbr_pkg::RTR_CYC) m.idle();
      m.col(dbr_pkg::COL_RD, 5'h09, 7'h00, 1'b0);
      chk(retire_pulse===1'b1 && pre_pulse===1'b0 && bank_active[3]===1'b1, "wrap");
      wait_pre(5'h03, dbr_pkg::OFFP_CYC, dbr_pkg::OFFP_CYC);
      $display("t_wr done");
   endtask : t_wr

   task automatic t_rdap;
      m.row(dbr_pkg::ROW_ACT, 5'h08, 9'h188);
      repeat (dbr_pkg::RCD_CYC + 1) m.idle();
      m.col(dbr_pkg::COL_RD_AP, 5'h08, 7'h00, 1'b1);
      wait_pre(5'h08, dbr_pkg::OFFP_CYC, dbr_pkg::OFFP_CYC);
      m.ext(5'h10);
      wait_pre(5'h10, dbr_pkg::OFFP_CYC, dbr_pkg::OFFP_CYC);
      chk(bank_active[8]===1'b0 && bank_active[16]===1'b0, "closed");
      $display("t_rdap done");
   endtask : t_rdap

   task automatic summarize;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      fails = 0;
      compares = 0;
      rst_b = 1'b0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      chk(bank_active===32'h0 && pre_pulse===1'b0, "reset");
      t_act();
      t_viol();
      t_wr();
      t_rdap();
      summarize();
   end
endmodule : test_dbr_bank_ctrl
